// File: design/per_router_consts.vh
// Purpose: Constants for the peripheral event router
// Assumes: Included by per_router.v only
// Notes:   Widths and timing counts shared by the design
//
// What this block does
// [RULE_01] Up to 64 sources, each may be shaped
// [RULE_02] Up to 32 channels, one per consumer
// [RULE_03] Channel carries events, tracks consumer ready/busy
// [RULE_04] Shaper synchronises and edge-detects selected sources
// [RULE_05] Pin sources pass optional spike filter first
// [RULE_06] Channels multiplex sources, emit fire strobe
// [RULE_07] Pin controller must set pin as input
// [RULE_08] Works idle; deep sleep needs clocks or wake
// [RULE_09] Async event revives only involved clocks
// [RULE_10] Revived clock released once function done
// [RULE_11] No processor wake unless consumer interrupts
// [RULE_12] Shaper event in sleep requests router clock
// [RULE_13] Power manager starts clock; event held meanwhile
// [RULE_14] Channel requests consumer clock, forwards fire
// [RULE_15] Consumer reports handling via ready/busy
// [RULE_16] Consumer back asleep: drop clock requests
// [RULE_17] Router clock needed for any propagation
// [RULE_18] Filter sampled from slow RC clock
// [RULE_19] Clock revival adds unbounded extra delay
// [RULE_20] Fixed latency, no bus transactions otherwise
// [RULE_21] Enabled, ready: forward, set trigger flag
// [RULE_22] Busy: discard event, set overrun flag
// [RULE_23] Filter needs two equal samples per edge
// [RULE_24] Unshaped zero latency; shaped within two; the code fires unshaped one clock and shaped five clocks after the input
// [RULE_25] Reset clears channels, flags, requests
`ifndef PER_ROUTER_CONSTS_VH
`define PER_ROUTER_CONSTS_VH
`define PER_NUM_SRC      64
`define PER_NUM_CH       32
`define PER_NUM_PIN      8
`define PER_SEL_W        6
`define PER_DIV_W        4
`define PER_DIV_CNT_W    16
`define PER_SYNC_STAGES  3
`define PER_RST_LEVEL    1'b0
`endif

// File: design/per_router.v
// Purpose: Event router from generators to consumer channels
// Assumes: clock_in is the router bus clock, gated by the power manager
// Notes:   Configuration and flag clears arrive as plain ports
`timescale 1ns/10ps
`include "per_router_consts.vh"
module per_router
#(
	parameter N_SRC    = `PER_NUM_SRC,
	parameter N_CH     = `PER_NUM_CH,
	parameter N_PIN    = `PER_NUM_PIN,
	parameter SEL_W    = `PER_SEL_W,
	parameter DIV_W    = `PER_DIV_W,
	parameter CNT_W    = `PER_DIV_CNT_W,
	parameter [`PER_NUM_SRC-1:0] WAKE_MASK = {`PER_NUM_SRC{1'b1}}
)
(
	input  wire                   clock_in,
	input  wire                   sys_rst_in,
	input  wire [N_PIN-1:0]       external_event_pins_in,
	input  wire [N_SRC-N_PIN-1:0] gen_event_in,
	input  wire [N_SRC-1:0]       shaper_en_in,
	input  wire [N_SRC-1:0]       filter_en_in,
	input  wire [DIV_W-1:0]       filter_sample_divider_in,
	input  wire                   slow_rc_clock_in,
	input  wire [N_CH-1:0]        ch_en_in,
	input  wire [N_CH*SEL_W-1:0]  ch_sel_in,
	input  wire [N_CH-1:0]        consumer_ready_in,
	input  wire [N_CH-1:0]        consumer_fire_strobe_flag_clr_in,
	input  wire [N_CH-1:0]        ovr_flag_clr_in,
	input  wire                   sleep_in,
	input  wire                   router_clk_running_in,
	output reg  [N_CH-1:0]        consumer_fire_strobe_out,
	output reg  [N_CH-1:0]        ch_busy_out,
	output reg  [N_CH-1:0]        consumer_fire_strobe_flag_out,
	output reg  [N_CH-1:0]        ovr_flag_out,
	output reg  [N_CH-1:0]        consumer_clk_req_out,
	output reg                    router_clk_req_out
);

	wire [N_SRC-1:0] raw_src;
	wire [N_SRC-1:0] src_evt;
	wire [N_SRC-1:0] pend_vec;
	wire [N_CH-1:0]  fire_nxt;
	wire [N_CH-1:0]  drop_nxt;
	wire [N_CH-1:0]  consumer_fire_strobe_nxt;
	wire [N_CH-1:0]  ovr_nxt;
	wire [N_CH-1:0]  creq_set;
	wire [N_CH-1:0]  creq_nxt;
	wire [N_CH-1:0]  busy_seen_nxt;
	wire             pend_any;
	wire             serv_any;
	wire             rreq_nxt;
	wire             clk_stopped;
	wire             hold;
	wire             rc_tick;

	reg  [`PER_SYNC_STAGES-1:0] rc_sync_r;
	reg                         rc_lvl_r;
	reg  [CNT_W-1:0]            rc_cnt_r;
	reg                         rc_tick_r;
	reg  [N_CH-1:0]             busy_seen_r;

	// Pins occupy the low source slots
	assign raw_src = {gen_event_in, external_event_pins_in};

	// Router clock stopped in sleep until the power manager grants it
	assign clk_stopped = sleep_in & ~router_clk_running_in; // RULE_17
	// Idle mode keeps its clock, so events wait only in deep sleep
	assign hold        = clk_stopped; // RULE_08 RULE_13

	// Slow RC clock sampled as an ordinary input
	always @(posedge clock_in)
	begin
		if (sys_rst_in)
		begin
			rc_sync_r <= {`PER_SYNC_STAGES{1'b0}};
			rc_lvl_r  <= `PER_RST_LEVEL;
			rc_cnt_r  <= {CNT_W{1'b0}};
			rc_tick_r <= 1'b0;
		end
		else
		begin
			rc_sync_r <= {rc_sync_r[`PER_SYNC_STAGES-2:0], slow_rc_clock_in};
			rc_tick_r <= 1'b0;
			if (rc_sync_r[1] == rc_sync_r[2])
			begin
				rc_lvl_r <= rc_sync_r[2];
				if (rc_sync_r[2] & ~rc_lvl_r)
				begin
					// Sample tick every 2^divider RC periods
					if (rc_cnt_r == (({{(CNT_W-1){1'b0}}, 1'b1} << filter_sample_divider_in)
						- {{(CNT_W-1){1'b0}}, 1'b1})) // RULE_18
					begin
						rc_cnt_r  <= {CNT_W{1'b0}};
						rc_tick_r <= 1'b1;
					end
					else
					begin
						rc_cnt_r <= rc_cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
					end
				end
			end
		end
	end
	assign rc_tick = rc_tick_r;

	genvar j;
	generate
		for (j = 0; j < N_SRC; j = j + 1) // RULE_01
		begin : g_src
			reg  [`PER_SYNC_STAGES-1:0] sync_r;
			reg                         lvl_r;
			reg                         smp_r;
			reg                         filt_r;
			reg                         prev_r;
			reg                         pend_r;
			wire                        shaped;
			wire                        edge_det;
			wire                        pend_nxt;

			// Three-stage synchroniser, level taken once the last two stages agree
			always @(posedge clock_in)
			begin
				if (sys_rst_in)
				begin
					sync_r <= {`PER_SYNC_STAGES{1'b0}};
					lvl_r  <= `PER_RST_LEVEL;
				end
				else
				begin
					sync_r <= {sync_r[`PER_SYNC_STAGES-2:0], raw_src[j]}; // RULE_04
					if (sync_r[1] == sync_r[2])
						lvl_r <= sync_r[2];
				end
			end

			// Spike filter, two equal samples move the level
			always @(posedge clock_in)
			begin
				if (sys_rst_in)
				begin
					smp_r  <= `PER_RST_LEVEL;
					filt_r <= `PER_RST_LEVEL;
				end
				else if (rc_tick)
				begin
					smp_r <= lvl_r; // RULE_18
					if ((smp_r == lvl_r) && (lvl_r != filt_r))
						filt_r <= lvl_r; // RULE_23
				end
			end

			// Edge memory and wake-up pending event
			always @(posedge clock_in)
			begin
				if (sys_rst_in)
				begin
					prev_r <= `PER_RST_LEVEL;
					pend_r <= 1'b0;
				end
				else
				begin
					prev_r <= shaped;
					pend_r <= pend_nxt; // RULE_12
				end
			end

			// Filter ahead of the edge detector
			assign shaped   = filter_en_in[j] ? filt_r : lvl_r; // RULE_05
			assign edge_det = shaped & ~prev_r; // RULE_04
			// Held for as long as the clock stays stopped
			assign pend_nxt = (edge_det & hold & WAKE_MASK[j]) | (pend_r & hold); // RULE_19
			assign pend_vec[j] = pend_r;
			// Unshaped sources pass straight through
			assign src_evt[j] = shaper_en_in[j] ?
				((edge_det | pend_r) & ~hold) : raw_src[j]; // RULE_20 RULE_24
		end
	endgenerate

	// Per-channel next values, one bit per consumer
	genvar i;
	generate
		for (i = 0; i < N_CH; i = i + 1) // RULE_02
		begin : g_ch
			wire [SEL_W-1:0] sel;
			wire             ev;
			wire             rdy;
			wire             done;

			// One selected generator per channel
			assign sel  = ch_sel_in[i*SEL_W +: SEL_W]; // RULE_06
			// Disabled channel ignores its source
			assign ev   = ch_en_in[i] & src_evt[sel]; // RULE_06
			assign rdy  = consumer_ready_in[i]; // RULE_03
			// Consumer has been busy and is ready again
			assign done = busy_seen_r[i] & rdy; // RULE_15

			// Accepted event, forwarded on the next clock edge
			assign fire_nxt[i] = ev & rdy; // RULE_21
			// Refused event while consumer busy
			assign drop_nxt[i] = ev & ~rdy; // RULE_22
			// Set wins over a clear in the same cycle
			assign consumer_fire_strobe_nxt[i] = fire_nxt[i] |
				(consumer_fire_strobe_flag_out[i] & ~consumer_fire_strobe_flag_clr_in[i]); // RULE_21
			assign ovr_nxt[i]  = drop_nxt[i] |
				(ovr_flag_out[i] & ~ovr_flag_clr_in[i]); // RULE_22
			// Only a channel forwarding in sleep asks for its clock
			assign creq_set[i] = fire_nxt[i] & sleep_in; // RULE_09 RULE_14
			// No wake of its own; request ends when consumer is done
			assign creq_nxt[i] = creq_set[i] |
				(consumer_clk_req_out[i] & ~done); // RULE_11 RULE_16
			// Busy seen only while the request stands
			assign busy_seen_nxt[i] = creq_nxt[i] & (busy_seen_r[i] | ~rdy); // RULE_15
		end
	endgenerate

	// Fire strobe, one cycle per accepted event
	always @(posedge clock_in)
	begin
		if (sys_rst_in)
		begin
			consumer_fire_strobe_out <= {N_CH{1'b0}}; // RULE_25
		end
		else
		begin
			consumer_fire_strobe_out <= fire_nxt; // RULE_21
		end
	end

	// Busy status follows consumer ready
	always @(posedge clock_in)
	begin
		if (sys_rst_in)
		begin
			ch_busy_out <= {N_CH{1'b0}}; // RULE_25
		end
		else
		begin
			ch_busy_out <= ~consumer_ready_in; // RULE_03
		end
	end

	// Sticky trigger flags
	always @(posedge clock_in)
	begin
		if (sys_rst_in)
		begin
			consumer_fire_strobe_flag_out <= {N_CH{1'b0}}; // RULE_25
		end
		else
		begin
			consumer_fire_strobe_flag_out <= consumer_fire_strobe_nxt; // RULE_21
		end
	end

	// Sticky overrun flags
	always @(posedge clock_in)
	begin
		if (sys_rst_in)
		begin
			ovr_flag_out <= {N_CH{1'b0}}; // RULE_25
		end
		else
		begin
			ovr_flag_out <= ovr_nxt; // RULE_22
		end
	end

	// Consumer clock requests
	always @(posedge clock_in)
	begin
		if (sys_rst_in)
		begin
			consumer_clk_req_out <= {N_CH{1'b0}}; // RULE_25
		end
		else
		begin
			consumer_clk_req_out <= creq_nxt; // RULE_14
		end
	end

	// Consumer busy seen during a request
	always @(posedge clock_in)
	begin
		if (sys_rst_in)
		begin
			busy_seen_r <= {N_CH{1'b0}};
		end
		else
		begin
			busy_seen_r <= busy_seen_nxt; // RULE_15
		end
	end

	// Router clock requested while anything pending or serviced
	assign pend_any = |pend_vec; // RULE_12
	assign serv_any = |creq_nxt; // RULE_14
	assign rreq_nxt = pend_any | serv_any; // RULE_10

	always @(posedge clock_in)
	begin
		if (sys_rst_in)
		begin
			router_clk_req_out <= 1'b0; // RULE_25
		end
		else
		begin
			router_clk_req_out <= rreq_nxt; // RULE_10
		end
	end

endmodule

// File: tb/per_props.sv
// Purpose: Port checker for per_router
// Assumes: Channel 0 watched
// Notes: Bound after the module
`timescale 1ns/10ps
module per_props(
	input wire clock_in, sys_rst_in, sleep_in, router_clk_running_in, router_clk_req_out,
	input wire [7:0] external_event_pins_in,
	input wire [55:0] gen_event_in,
	input wire [63:0] shaper_en_in,
	input wire [191:0] ch_sel_in,
	input wire [31:0] ch_en_in, consumer_ready_in, consumer_fire_strobe_out,
	input wire [31:0] ch_busy_out, consumer_fire_strobe_flag_out, ovr_flag_out, consumer_clk_req_out
);
wire [63:0] src = {gen_event_in, external_event_pins_in};
wire [5:0] sel = ch_sel_in[5:0];
default clocking @(posedge clock_in); endclocking
default disable iff (sys_rst_in);
sequence s_back;
	consumer_clk_req_out[0] && consumer_ready_in[0] && !$past(consumer_ready_in[0]);
endsequence
property p_rst;
	$fell(sys_rst_in) |-> !(consumer_fire_strobe_out | ch_busy_out | consumer_fire_strobe_flag_out
		| ovr_flag_out | consumer_clk_req_out) && !router_clk_req_out;
endproperty
property p_fire;
	consumer_fire_strobe_out[0] |-> $past(ch_en_in[0] && consumer_ready_in[0]);
endproperty
property p_consumer_fire_strobe;
	consumer_fire_strobe_out[0] |-> consumer_fire_strobe_flag_out[0];
endproperty
property p_ovr;
	$rose(ovr_flag_out[0]) |-> $past(!consumer_ready_in[0]) && !consumer_fire_strobe_out[0];
endproperty
property p_lat0;
	ch_en_in[0] && consumer_ready_in[0] && !shaper_en_in[sel] && src[sel]
		|=> consumer_fire_strobe_out[0];
endproperty
property p_busy;
	!$past(sys_rst_in) |-> ch_busy_out[0] == !$past(consumer_ready_in[0]);
endproperty
property p_rreq;
	$rose(router_clk_req_out) |-> $past(sleep_in && !router_clk_running_in);
endproperty
property p_creq;
	$rose(consumer_clk_req_out[0]) |-> consumer_fire_strobe_out[0];
endproperty
property p_drop;
	s_back |=> !consumer_clk_req_out[0];
endproperty
property p_rel;
	$fell(consumer_clk_req_out[0]) |=> !router_clk_req_out;
endproperty
a_rst: assert property (p_rst) else $error("outputs not clear");
a_fire: assert property (p_fire) else $error("fire without cause");
a_consumer_fire_strobe: assert property (p_consumer_fire_strobe) else $error("consumer_fire_strobe flag missing");
a_ovr: assert property (p_ovr) else $error("overrun wrong");
a_lat0: assert property (p_lat0) else $error("direct fire late");
a_busy: assert property (p_busy) else $error("busy not tracked");
a_rreq: assert property (p_rreq) else $error("clock request early");
a_creq: assert property (p_creq) else $error("consumer request alone");
a_drop: assert property (p_drop) else $error("consumer request kept");
a_rel: assert property (p_rel) else $error("router request kept");
endmodule
bind per_router per_props chk(.*);

// File: tb/per_partner.sv
// Purpose: Consumer 0 and power manager model
// Assumes: Acts on falling clock edges
// Notes: LAG sets clock revival delay
`timescale 1ns/10ps
module per_partner #(parameter LAG = 3)(
	input  wire  clock_in,
	input  wire  sleep_in,
	input  wire  clk_req_in,
	input  wire  fire_in,
	input  wire  busy_in,
	output logic running_out = 1'b1,
	output logic ready_out = 1'b1
);
int w = 0;
int b = 0;
always @(negedge clock_in)
begin
	w <= clk_req_in ? w + 1 : 0;
	running_out <= !sleep_in || (clk_req_in && w >= LAG);
	b <= fire_in ? 3 : (b > 0 ? b - 1 : 0);
	ready_out <= !(busy_in || fire_in || b > 1);
end
endmodule

// File: tb/test_per_router.sv
// Purpose: Bench for per_router
// Assumes: Channel 0 carries all traffic
// Notes: Partner plays consumer and power manager
`timescale 1ns/10ps
module test_per_router;
logic clock_in = 0, sys_rst_in = 1, rc = 0, sleep = 0, busy = 0, run, rdy, rreq;
logic [7:0] pins = 0;
logic [3:0] div = 4'h0;
logic [55:0] gen = 0;
logic [63:0] shp = 0, flt = 0;
logic [31:0] en = 0, clr = 0, fire, bsy, consumer_fire_strobe, ovr, creq;
logic [191:0] sel = 0;
int failures = 0, n_checks = 0, cyc = 0;
always #5 clock_in = ~clock_in;
always #40 rc = ~rc;
per_router uut(.clock_in(clock_in), .sys_rst_in(sys_rst_in), .external_event_pins_in(pins),
	.gen_event_in(gen), .shaper_en_in(shp), .filter_en_in(flt), .filter_sample_divider_in(div),
	.slow_rc_clock_in(rc), .ch_en_in(en), .ch_sel_in(sel), .consumer_ready_in({31'h7FFFFFFF, rdy}),
	.consumer_fire_strobe_flag_clr_in(clr), .ovr_flag_clr_in(clr), .sleep_in(sleep), .router_clk_running_in(run),
	.consumer_fire_strobe_out(fire), .ch_busy_out(bsy), .consumer_fire_strobe_flag_out(consumer_fire_strobe),
	.ovr_flag_out(ovr), .consumer_clk_req_out(creq), .router_clk_req_out(rreq));
per_partner pm(.clock_in(clock_in), .sleep_in(sleep), .clk_req_in(rreq), .fire_in(fire[0]),
	.busy_in(busy), .running_out(run), .ready_out(rdy));
task chk(string s, logic [31:0] v, e);
	n_checks++;
	if (v !== e) failures++;
	if (v !== e) $display("Error %s expected %h seen %h", s, e, v);
endtask
task tick(int n);
	repeat (n) @(negedge clock_in);
endtask
task wait_fire(int lim, logic e, string s);
	for (int k = 0; k < lim && fire[0] !== 1'b1; k++) tick(1);
	chk(s, fire[0], e);
endtask
task tally_and_finish;
	$display("checks %0d failures %0d", n_checks, failures);
	if (failures == 0 && n_checks > 0) $display("Result: passed");
	else $display("Result: failed");
	$finish;
endtask
task t_direct;
	sel[5:0] = 6'h08; en[0] = 1; gen[0] = 1; tick(1);
	chk("fire", fire[0], 1);
	chk("consumer_fire_strobe", consumer_fire_strobe[0], 1);
	tick(1); gen[0] = 0;
	chk("refused", fire[0], 0);
	chk("ovr", ovr[0], 1);
	chk("busy", bsy[0], 1);
	clr[0] = 1; tick(1); clr[0] = 0;
	chk("cleared", consumer_fire_strobe[0] | ovr[0], 0);
	tick(6); en[0] = 0; gen[0] = 1; tick(2); gen[0] = 0;
	chk("disabled", fire[0] | consumer_fire_strobe[0], 0);
	en[0] = 1;
endtask
task t_shaped(logic f);
	sel[5:0] = 6'h00; shp[0] = 1; flt[0] = f; pins[0] = 1;
	div = {3'h0, f};
	wait_fire(f ? 60 : 5, 1, "shaped");
	tick(1); pins[0] = 0; tick(60);
	pins[0] = 1; tick(1); pins[0] = 0;
	if (f) wait_fire(40, 0, "spike");
	tick(10);
endtask
task t_sleep;
	flt[0] = 0; sleep = 1; tick(3); pins[0] = 1;
	for (int k = 0; k < 10 && rreq !== 1'b1; k++) tick(1);
	chk("router req", rreq, 1);
	wait_fire(20, 1, "woken fire");
	chk("consumer req", creq[0], 1);
	for (int k = 0; k < 10 && creq[0] !== 1'b0; k++) tick(1);
	chk("consumer drop", creq[0], 0);
	tick(1);
	chk("router drop", rreq, 0);
	sleep = 0; pins[0] = 0;
endtask
always @(posedge clock_in)
begin
	cyc++;
	if (cyc == 3000) failures++;
	if (cyc == 3000) tally_and_finish;
end
initial
begin
	tick(20); sys_rst_in = 0; tick(1);
	chk("reset", fire | bsy | consumer_fire_strobe | ovr | creq | rreq, 0);
	t_direct;
	t_shaped(0);
	t_shaped(1);
	t_sleep;
	tally_and_finish;
end
endmodule
